// [rtl/swb_card_link.sv]
// Card-side bit decoder and load-current encoder for the single-wire link
`timescale 1ns/1ps

// Operation
// - Two successive rising edges of the voltage line bound a bit
// - Every bit may have its own period; decoder measures each one
// - Bit period 1 to 5 us, or 0.59 to 10 us when extended
// - Card answers only by switching load current on the contact
// - Card switches load current only while line is low, except resume
// - Bits go most significant first in both directions
// - Suspended line stays high, no current; resume raises current
module swb_card_link (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Shared contact, voltage level seen by the card
  input wire logic voltage_line_signal_in,
  // Shared contact, load current switch
  output logic load_current_signal_out,
  // Link configuration
  input wire logic ext_range_in,
  // Received bytes
  output logic rx_valid_out,
  output logic [swb_pkg::BYTE_W-1:0] rx_data_out,
  input wire logic rx_ready_in,
  // Bytes to send
  input wire logic tx_valid_in,
  input wire logic [swb_pkg::BYTE_W-1:0] tx_data_in,
  output logic tx_ready_out,
  // Resume from suspended state
  input wire logic resume_req_in,
  // Status
  output logic bit_error_out,
  output logic overrun_out
);
  import swb_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic line_d;
    rx_state_t rx_state;
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic [2:0] rx_bit;
    logic [BYTE_W-1:0] rx_shift;
    logic push;
    logic [BYTE_W-1:0] push_data;
    logic [2:0] tx_bit;
    logic [BYTE_W-1:0] tx_shift;
    logic tx_busy;
    logic current;
    logic bit_err;
    logic overrun;
  } card_st_t;

  card_st_t st;
  card_st_t next_st;
  logic rise;
  logic fall;
  logic fifo_ready;
  logic period_ok;
  logic bit_value;
  logic [CNT_W-1:0] min_cyc;
  logic [CNT_W-1:0] max_cyc;

  // -------------------------------------------------------------------
  // Edge detection
  // -------------------------------------------------------------------
  // Only the second synchroniser stage feeds logic
  assign rise = st.sync2 && !st.line_d;
  assign fall = !st.sync2 && st.line_d;

  assign min_cyc = ext_range_in ? CNT_W'(BIT_MIN_EXT_CYC)
                                : CNT_W'(BIT_MIN_DEF_CYC);
  assign max_cyc = ext_range_in ? CNT_W'(BIT_MAX_EXT_CYC)
                                : CNT_W'(BIT_MAX_DEF_CYC);
  assign period_ok = (st.period_cnt >= min_cyc) && (st.period_cnt <= max_cyc);
  assign bit_value = ({st.high_cnt, 1'b0} > {1'b0, st.period_cnt});

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sync1 = voltage_line_signal_in;
    next_st.sync2 = st.sync1;
    next_st.line_d = st.sync2;
    next_st.push = 1'b0;
    // Period and high time saturate so an idle line cannot wrap
    if (st.period_cnt != CNT_SAT) begin
      next_st.period_cnt = st.period_cnt + 1'b1;
    end
    if (st.sync2 && st.high_cnt != CNT_SAT) begin
      next_st.high_cnt = st.high_cnt + 1'b1;
    end
    case (st.rx_state)
      RX_WAIT_EDGE: begin
        // first rising edge opens a bit
        if (rise) begin
          next_st.rx_state = RX_IN_BIT;
          next_st.period_cnt = CNT_W'(1);
          next_st.high_cnt = CNT_W'(1);
        end
      end
      RX_IN_BIT: begin
        // ending edge also opens the next bit
        if (rise) begin
          // each bit judged on its own period
          if (period_ok) begin
            next_st.rx_shift = {st.rx_shift[BYTE_W-2:0], bit_value};
            next_st.rx_bit = st.rx_bit - 1'b1;
            if (st.rx_bit == 3'h0) begin
              next_st.push = 1'b1;
              next_st.push_data = {st.rx_shift[BYTE_W-2:0], bit_value};
            end
          end else begin
            next_st.bit_err = 1'b1;
            next_st.rx_bit = BIT_CNT_RST;
          end
          next_st.period_cnt = CNT_W'(1);
          next_st.high_cnt = CNT_W'(1);
        end else if (st.period_cnt > max_cyc && st.sync2) begin
          // Line held high: suspended, drop any partial byte
          next_st.rx_state = RX_WAIT_EDGE;
          next_st.rx_bit = BIT_CNT_RST;
        end
      end
      default: next_st.rx_state = RX_WAIT_EDGE;
    endcase
    // Full FIFO loses the byte; flagged as overrun
    if (st.push && !fifo_ready) begin
      next_st.overrun = 1'b1;
    end
    // current changes on falling edge (line low), or on resume while line is high
    if (fall) begin
      if (st.tx_busy) begin
        next_st.current = st.tx_shift[BYTE_W-1];
        next_st.tx_shift = {st.tx_shift[BYTE_W-2:0], 1'b0};
        next_st.tx_bit = st.tx_bit - 1'b1;
        if (st.tx_bit == 3'h0) begin
          next_st.tx_busy = 1'b0;
        end
      end else if (tx_valid_in) begin
        next_st.current = tx_data_in[BYTE_W-1];
        next_st.tx_shift = {tx_data_in[BYTE_W-2:0], 1'b0};
        next_st.tx_bit = 3'h6;
        next_st.tx_busy = 1'b1;
      end else begin
        next_st.current = 1'b0;
      end
    end else if (st.rx_state == RX_WAIT_EDGE && st.sync2 && resume_req_in
                 && !st.tx_busy) begin
      // resume: raise current while line is held high
      next_st.current = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // Synchroniser and edge history start at the idle high level
      st <= '{default: '0, rx_state: RX_WAIT_EDGE, rx_bit: BIT_CNT_RST,
              period_cnt: CNT_RST, high_cnt: CNT_RST, sync1: LINE_RST,
              sync2: LINE_RST, line_d: LINE_RST};
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------
  // Receive buffering
  // -------------------------------------------------------------------
  swb_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(st.push),
    .in_data_in(st.push_data),
    .in_ready_out(fifo_ready),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_data_out),
    .out_ready_in(rx_ready_in)
  );

  // Outputs
  assign load_current_signal_out = st.current;
  // Byte taken only on a falling edge while idle
  assign tx_ready_out = fall && !st.tx_busy;
  assign bit_error_out = st.bit_err;
  assign overrun_out = st.overrun;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_current_switch_low: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    $changed(st.current) && $past(st.sync2) |->
      $past(st.rx_state) == RX_WAIT_EDGE && st.current)
    else $error("load current switched while line high");
  a_bit_decode_msb: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    st.rx_state == RX_IN_BIT && rise && period_ok |=>
      st.rx_shift[0] == $past(bit_value))
    else $error("decoded bit not shifted into lsb");
  a_half_compare: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    bit_value |-> st.high_cnt > (st.period_cnt >> 1))
    else $error("bit value disagrees with half period");
  a_edge_restart: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    rise |=> st.period_cnt == CNT_W'(1) && st.rx_state == RX_IN_BIT)
    else $error("rising edge did not restart bit");
  a_range_error: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    st.rx_state == RX_IN_BIT && rise && !period_ok |=> st.bit_err)
    else $error("out-of-range period not flagged");
  a_push_byte: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in)
    st.push |-> $past(st.rx_bit) == 3'h0 && $past(rise))
    else $error("byte pushed without eighth bit");
  c_byte_rx: cover property (@(posedge sys_clk_in) st.push);
  c_byte_tx: cover property (@(posedge sys_clk_in)
    fall && tx_valid_in && !st.tx_busy);
  c_resume: cover property (@(posedge sys_clk_in)
    st.sync2 && $rose(st.current));
endmodule

// [rtl/swb_pkg.sv]
// Constants and types shared by the card-side bit coding logic
package swb_pkg;
  // Clock period in picoseconds (200 MHz)
  localparam int CLK_PERIOD_PS = 5000;
  // Bit period limits in nanoseconds
  localparam int BIT_MIN_DEF_NS = 1000;
  localparam int BIT_MAX_DEF_NS = 5000;
  localparam int BIT_MIN_EXT_NS = 590;
  localparam int BIT_MAX_EXT_NS = 10000;
  // Longest extended bit period in cycles, rounded down
  localparam int BIT_MAX_EXT_CYC = (BIT_MAX_EXT_NS * 1000) / CLK_PERIOD_PS;
  // Shortest default bit period in cycles, rounded up
  localparam int BIT_MIN_DEF_CYC =
    (BIT_MIN_DEF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Shortest extended bit period in cycles, rounded up
  localparam int BIT_MIN_EXT_CYC =
    (BIT_MIN_EXT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest default bit period in cycles, rounded down
  localparam int BIT_MAX_DEF_CYC = (BIT_MAX_DEF_NS * 1000) / CLK_PERIOD_PS;
  // Counter width, enough for the extended maximum and headroom
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_SAT = 12'hFFF;
  // Bytes carried by the link
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] BIT_CNT_RST = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  // Idle level of the voltage line, so reset shows no false edge
  localparam logic LINE_RST = 1'b1;

  // Receive state of the decoder
  typedef enum logic [1:0] {
    RX_WAIT_EDGE = 2'b00,
    RX_IN_BIT = 2'b01
  } rx_state_t;
endpackage

// [rtl/swb_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module swb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t st;
  fifo_st_t next_st;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count
  assign in_ready_out = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out = st.mem[st.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Next state of pointers and storage
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data_in;
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge sys_clk_in)
    disable iff (!nrst_in) st.cnt <= (AW+1)'(DEPTH))
    else $error("fifo accepts data while full");
endmodule

// [tb/swb_master_model.sv]
// Behavioural link master: drives the voltage line, reads load current
`timescale 1ns/1ps
module swb_master_model (
  // Link contact
  output logic line_out,
  input wire logic current_in
);
  logic [7:0] seen;

  // Line rests high, as in the suspended state
  initial begin
    line_out = 1'b1;
    seen = 8'h00;
  end

  // Short low pulse; its rise opens the first bit of a burst
  task automatic start();
    line_out = 1'b0;
    #240;
    line_out = 1'b1;
  endtask

  // next bit opens at this rise
  task automatic send_bit(input logic v, input int n);
    int hi;
    hi = v ? n * 36 : n * 12;
    #(hi / 2);
    seen = {seen[6:0], current_in};
    #(hi - hi / 2);
    line_out = 1'b0;
    #(n * 48 - hi);
    line_out = 1'b1;
  endtask

  // period grows by one step per bit
  task automatic send_byte(input logic [7:0] b, input int n);
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i], n + 7 - i);
    end
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the card-side link block
`timescale 1ns/1ps
module tb_top;
  import swb_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic line, cur, ext, rxv, rxr, txv, txr, res, berr, ovr;
  logic prev_cur = 1'b0;
  logic tx_took = 1'b0;
  logic [BYTE_W-1:0] rxd, txd;
  int mismatches = 0;
  int num_checks = 0;

  initial forever #2.5 sys_clk = ~sys_clk;

  swb_card_link dut_u (.sys_clk_in(sys_clk), .nrst_in(nrst),
    .voltage_line_signal_in(line), .load_current_signal_out(cur),
    .ext_range_in(ext), .rx_valid_out(rxv), .rx_data_out(rxd),
    .rx_ready_in(rxr), .tx_valid_in(txv), .tx_data_in(txd),
    .tx_ready_out(txr), .resume_req_in(res), .bit_error_out(berr),
    .overrun_out(ovr));

  swb_master_model mst_u (.line_out(line), .current_in(cur));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for a byte, then take it in one cycle
  task automatic pop(input logic [7:0] exp);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (rxv !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    if (rxv !== 1'b1) begin
      mismatches++;
      $display("[ERR] rx_valid expected 1 seen %b", rxv);
      end_of_test();
    end else begin
      check("rx_data", exp, rxd);
      rxr = 1'b1;
      @(negedge sys_clk);
      rxr = 1'b0;
    end
  endtask

  // Drop the request once the block has taken the byte
  always @(posedge sys_clk) tx_took <= txv & txr;
  always @(negedge sys_clk) if (tx_took) txv = 1'b0;

  // Current must hold still while the line is high, resume aside
  always @(posedge sys_clk) begin
    if (nrst && cur !== prev_cur && line === 1'b1 && res !== 1'b1) begin
      mismatches++;
      $display("[ERR] current_switch expected 0 seen 1");
    end
    prev_cur <= cur;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_rx_ext();
    @(negedge sys_clk);
    ext = 1'b1;
    mst_u.start();
    mst_u.send_byte(8'hA5, 13);
    #11000;
    pop(8'hA5);
    check("bit_error", 8'h00, {7'h00, berr});
    @(negedge sys_clk);
    ext = 1'b0;
    $display("test rx_ext done");
  endtask

  // Fill the FIFO past its depth while the consumer stalls
  task automatic t_fifo();
    logic [7:0] b [5] = '{8'h3C, 8'h81, 8'hFF, 8'h00, 8'h5A};
    mst_u.start();
    for (int i = 0; i < 5; i++) mst_u.send_byte(b[i], 21);
    #6000;
    check("overrun", 8'h01, {7'h00, ovr});
    for (int i = 0; i < 4; i++) pop(b[i]);
    check("rx_valid", 8'h00, {7'h00, rxv});
    $display("test fifo done");
  endtask

  task automatic t_tx();
    @(negedge sys_clk);
    txd = 8'hC3;
    txv = 1'b1;
    mst_u.start();
    mst_u.send_byte(8'h00, 21);
    check("master_seen", 8'hC3, mst_u.seen);
    check("tx_taken", 8'h00, {7'h00, txv});
    #6000;
    pop(8'h00);
    $display("test tx done");
  endtask

  // Too short a period for the default range
  task automatic t_err();
    check("idle_current", 8'h00, {7'h00, cur});
    mst_u.start();
    mst_u.send_bit(1'b1, 19);
    mst_u.send_bit(1'b0, 19);
    check("bit_error", 8'h01, {7'h00, berr});
    #6000;
    $display("test err done");
  endtask

  task automatic t_resume();
    @(negedge sys_clk);
    res = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("resume_current", 8'h01, {7'h00, cur});
    $display("test resume done");
  endtask

  initial begin
    ext = 1'b0;
    rxr = 1'b0;
    txv = 1'b0;
    txd = 8'h00;
    res = 1'b0;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    #1.3;
    t_rx_ext();
    t_fifo();
    t_tx();
    t_err();
    t_resume();
    end_of_test();
  end
endmodule
